// >>> spp_pkg.sv
// Package for the serial peripheral port: field positions, reset values, carriers.
// Assumes a single bus clock domain; serial pins are sampled as synchronous inputs.
package spp_pkg;
	localparam int WORD_BITS     = 16;
	localparam int CTRL_SEL_BIT  = 0;
	localparam int FMT_PHASE_BIT = 16;
	localparam int FMT_POL_BIT   = 17;
	localparam int FMT_PS_LSB    = 8;
	localparam int FMT_PS_MSB    = 15;
	localparam int FIFO_DEPTH    = 32;
	localparam logic [31:0] FMT_RESET  = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	typedef struct packed {
		logic        sel;
		logic        ssel_n;
		logic        sclk;
		logic        mosi;
	} spp_pins_t;

	typedef struct packed {
		logic        sample_rise;
		logic        launch_rise;
	} spp_edges_t;
endpackage

// >>> spp_port.sv
// Serial peripheral port: peripheral-mode shifter plus a 32-word receive FIFO.
// Assumes the bus clock is well above the serial clock so pins can be oversampled.
// How it works
// - Peripheral mode when control bit 0 clear
// - Format bit 16 selects clock phase
// - Format bit 17 selects clock polarity
// - Prescale bits 15:8 bound serial clock period
// - Pol/phase equal: sample on falling edge
// - Pol/phase differ: sample on rising edge
// - Pol/phase equal: update after rising edge
// - Pol/phase differ: update after falling edge
`timescale 1ns/100ps
module spp_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp;
	logic [AW:0]      rp;
	logic [AW:0]      next_wp;
	logic [AW:0]      next_rp;
	logic             push;
	logic             pop;

	always_comb begin
		in_ready  = (wp - rp) != (AW+1)'(DEPTH);
		out_valid = wp != rp;
		push      = ce && in_valid && in_ready;
		pop       = ce && out_valid && out_ready;
		next_wp   = push ? wp + 1'b1 : wp;
		next_rp   = pop ? rp + 1'b1 : rp;
		out_data  = mem[rp[AW-1:0]];
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wp <= '0;
			rp <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
		end
		if (push) begin
			mem[wp[AW-1:0]] <= in_data;
		end
	end
endmodule

module spp_port #(
	parameter int WORD = spp_pkg::WORD_BITS,
	parameter int DEPTH = spp_pkg::FIFO_DEPTH
) (
	input  wire logic            CLK,
	input  wire logic            RST,
	input  wire logic            CE,
	input  wire logic [31:0]     GLOBAL_CONTROL_REG,
	input  wire logic [31:0]     FORMAT_REG,
	input  wire logic            CHIP_SELECT_N,
	input  wire logic            SERIAL_CLOCK_IN,
	input  wire logic            HOST_TO_PERIPH_LINE,
	output logic                 PERIPH_TO_HOST_LINE,
	output logic                 PERIPH_TO_HOST_OE,
	input  wire logic [WORD-1:0] TX_WORD,
	input  wire logic            TX_VALID,
	output logic                 TX_READY,
	output logic [WORD-1:0]      RX_WORD,
	output logic                 RX_VALID,
	input  wire logic            RX_READY,
	output logic                 RX_OVERRUN,
	output logic                 ACTIVE,
	output logic [7:0]           CLOCK_PRESCALE
);
	// Counter runs to WORD, one past the last bit index, so it needs an extra code
	localparam int               cnt_w    = $clog2(WORD + 1);
	localparam logic [cnt_w-1:0] cnt_zero = cnt_w'(0);
	localparam logic [cnt_w-1:0] cnt_one  = cnt_w'(1);
	localparam logic [cnt_w-1:0] cnt_last = cnt_w'(WORD - 1);
	localparam logic [cnt_w-1:0] cnt_full = cnt_w'(WORD);

	spp_pkg::spp_pins_t  pins;
	spp_pkg::spp_edges_t edg;
	logic                sclk_d;
	logic [cnt_w-1:0]    cnt;
	logic [cnt_w-1:0]    next_cnt;
	logic [WORD-1:0]     rx_sh;
	logic [WORD-1:0]     next_rx_sh;
	logic [WORD-1:0]     tx_sh;
	logic [WORD-1:0]     next_tx_sh;
	logic                sdo;
	logic                next_sdo;
	logic                fin;
	logic                next_fin;
	logic                next_ovr;
	logic                f_ready;
	logic                rise;
	logic                fall;
	logic                smp;
	logic                lau;
	logic                phase;
	logic                pol;
	logic                first_out;
	logic                shift_out;
	logic                take_in;

	// Prescale exported for the host-side divider setting; period >= value+1 bus clocks
	assign CLOCK_PRESCALE = FORMAT_REG[spp_pkg::FMT_PS_MSB:spp_pkg::FMT_PS_LSB];

	// Sampling and launching pick their edge the same way
	function automatic logic pick_edge(
		input logic want_rise,
		input logic r,
		input logic f
	);
		return want_rise ? r : f;
	endfunction

	always_comb begin
		pins.sel    = ~GLOBAL_CONTROL_REG[spp_pkg::CTRL_SEL_BIT];
		pins.ssel_n = CHIP_SELECT_N;
		pins.sclk   = SERIAL_CLOCK_IN;
		pins.mosi   = HOST_TO_PERIPH_LINE;
		phase       = FORMAT_REG[spp_pkg::FMT_PHASE_BIT];
		pol         = FORMAT_REG[spp_pkg::FMT_POL_BIT];
		edg.sample_rise = pol ^ phase;
		edg.launch_rise = ~(pol ^ phase);
		rise = pins.sclk & ~sclk_d;
		fall = ~pins.sclk & sclk_d;
		smp  = pick_edge(edg.sample_rise, rise, fall);
		lau  = pick_edge(edg.launch_rise, rise, fall);
		// Mode bit and select gate everything below; outside that the pins are ignored
		ACTIVE = pins.sel && !pins.ssel_n;
		// Phase 0 puts the top bit out on the first launch edge and shifts on later ones
		first_out = lau && !phase && cnt == cnt_zero;
		shift_out = lau && !first_out && cnt != cnt_full;
		take_in   = smp && cnt != cnt_full;

		next_cnt   = cnt;
		next_rx_sh = rx_sh;
		next_tx_sh = tx_sh;
		next_sdo   = sdo;
		next_fin   = 1'b0;
		next_ovr   = RX_OVERRUN;
		TX_READY   = 1'b0;
		if (!ACTIVE) begin
			// Load while idle: phase 1 samples first, so the top bit must already be out
			next_cnt   = cnt_zero;
			next_tx_sh = TX_VALID ? TX_WORD : '0;
			TX_READY   = 1'b1;
			next_sdo   = next_tx_sh[WORD-1];
		end else begin
			if (shift_out) begin
				next_tx_sh = {tx_sh[WORD-2:0], 1'b0};
				next_sdo   = tx_sh[WORD-2];
			end
			if (first_out) begin
				next_sdo = tx_sh[WORD-1];
			end
			if (take_in) begin
				next_rx_sh = {rx_sh[WORD-2:0], pins.mosi};
				next_cnt   = cnt + cnt_one;
				next_fin   = cnt == cnt_last;
			end
		end
		// Overrun is sticky until reset; a word is dropped rather than stalling the host
		if (fin && !f_ready) begin
			next_ovr = 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			sclk_d     <= 1'b0;
			cnt        <= '0;
			rx_sh      <= '0;
			tx_sh      <= '0;
			sdo        <= 1'b0;
			fin        <= 1'b0;
			RX_OVERRUN <= 1'b0;
			PERIPH_TO_HOST_OE <= 1'b0;
		end else if (CE) begin
			sclk_d     <= pins.sclk;
			cnt        <= next_cnt;
			rx_sh      <= next_rx_sh;
			tx_sh      <= next_tx_sh;
			sdo        <= next_sdo;
			fin        <= next_fin;
			RX_OVERRUN <= next_ovr;
			// Registered, so the line is let go one bus clock after select rises
			PERIPH_TO_HOST_OE <= ACTIVE;
		end
	end

	assign PERIPH_TO_HOST_LINE = sdo;

	spp_fifo #(
		.WIDTH(WORD),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk      (CLK),
		.rst      (RST),
		.ce       (CE),
		.in_valid (fin),
		.in_ready (f_ready),
		.in_data  (rx_sh),
		.out_valid(RX_VALID),
		.out_ready(RX_READY),
		.out_data (RX_WORD)
	);
endmodule

// >>> spp_port_asserts.sv
// Port checker for spp_port
// Bound from the bench; CE held high
`timescale 1ns/100ps
module spp_asserts (input wire logic CLK, RST, ACTIVE, CHIP_SELECT_N,
	PERIPH_TO_HOST_OE, RX_VALID, RX_READY, RX_OVERRUN,
	input wire logic [31:0] GLOBAL_CONTROL_REG, FORMAT_REG,
	input wire logic [15:0] RX_WORD, input wire logic [7:0] CLOCK_PRESCALE);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	property p_act; ACTIVE == !(GLOBAL_CONTROL_REG[0] | CHIP_SELECT_N); endproperty
	a_act: assert property (p_act) else $error("act");
	property p_on; ACTIVE |=> PERIPH_TO_HOST_OE; endproperty
	a_on: assert property (p_on) else $error("oe on");
	property p_off; CHIP_SELECT_N |=> !PERIPH_TO_HOST_OE; endproperty
	a_off: assert property (p_off) else $error("oe off");
	property p_mode; GLOBAL_CONTROL_REG[0] |=> !PERIPH_TO_HOST_OE; endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_ps; CLOCK_PRESCALE == FORMAT_REG[15:8]; endproperty
	a_ps: assert property (p_ps) else $error("ps");
	property p_hold; RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_WORD); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_ovr; RX_OVERRUN |=> RX_OVERRUN; endproperty
	a_ovr: assert property (p_ovr) else $error("ovr");
	property p_rst; $fell(RST) |-> !PERIPH_TO_HOST_OE && !RX_VALID; endproperty
	a_rst: assert property (p_rst) else $error("rst");
endmodule

// >>> spp_host_model.sv
// Host controller model
// Serial clock 8 bus clocks, still between frames
`timescale 1ns/100ps
module spp_host_model (input wire logic CLK, pol, pha, miso,
	output logic cs_n = 1'b1, sclk = 1'b0, mosi = 1'b0);
	task automatic xfer(input logic [15:0] w, output logic [15:0] r);
		@(posedge CLK) sclk <= pol;
		@(posedge CLK) cs_n <= 1'b0;
		repeat (16) @(posedge CLK);
		for (int i = 15; i >= 0; i--) begin
			repeat (3) @(posedge CLK);
			mosi <= w[i];
			@(posedge CLK) if (pha) r[i] = miso;
			sclk <= ~sclk;
			repeat (4) @(posedge CLK);
			if (!pha) r[i] = miso;
			sclk <= ~sclk;
		end
		repeat (4) @(posedge CLK);
		cs_n <= 1'b1;
		mosi <= ~mosi;
	endtask
endmodule

// >>> spp_port_tb_top.sv
// Bench for spp_port
// Host model drives the serial side
`timescale 1ns/100ps
module spp_port_tb_top;
	logic clk = 1'b0, rst = 1'b1, rdy = 1'b0, txv = 1'b1, cs_n, sclk, mosi, miso, rv, ovr;
	logic oe, p2h, txr;
	logic [31:0] ctl = 32'h0, fmt = 32'h0000_0700;
	logic [15:0] txw = 16'h0, rw, r, g;
	int fail_count = 0, n_tests = 0;
	initial forever #10 clk = ~clk;
	// A released line shows the inverse of its last bit, so a stray sample is caught
	assign miso = oe ? p2h : ~p2h;
	initial begin #400us; fail_count++; stop_test(); end
	spp_host_model u_host (.CLK(clk), .pol(fmt[17]), .pha(fmt[16]), .miso(miso),
		.cs_n(cs_n), .sclk(sclk), .mosi(mosi));
	spp_port u_dut (.CLK(clk), .RST(rst), .CE(1'b1), .GLOBAL_CONTROL_REG(ctl),
		.FORMAT_REG(fmt), .CHIP_SELECT_N(cs_n), .SERIAL_CLOCK_IN(sclk),
		.HOST_TO_PERIPH_LINE(mosi), .PERIPH_TO_HOST_LINE(p2h), .PERIPH_TO_HOST_OE(oe),
		.TX_WORD(txw), .TX_VALID(txv), .TX_READY(txr), .RX_WORD(rw), .RX_VALID(rv),
		.RX_READY(rdy), .RX_OVERRUN(ovr), .ACTIVE(), .CLOCK_PRESCALE());
	task automatic chk(input string s, input logic [15:0] e, v);
		n_tests++;
		if (v !== e) begin
			fail_count++;
			$display("wrong value %s exp %h seen %h", s, e, v);
		end
	endtask
	task automatic send(input logic [15:0] w);
		txw <= ~w;
		u_host.xfer(w, r);
	endtask
	task automatic pop();
		@(negedge clk);
		repeat (40) if (rv !== 1'b1) @(negedge clk);
		chk("rx valid", 16'h1, {15'h0, rv});
		g = rw;
		@(posedge clk) rdy <= 1'b1;
		@(posedge clk) rdy <= 1'b0;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			fmt[17:16] <= 2'(m);
			send(16'ha5c3 ^ 16'(m));
			chk("miso", ~(16'ha5c3 ^ 16'(m)), r);
			pop();
			chk("rx", 16'ha5c3 ^ 16'(m), g);
			chk("tx ready", 16'h1, {15'h0, txr});
		end
		txv <= 1'b0;
		send(16'h5a5a);
		chk("idle tx", 16'h0, r);
		txv <= 1'b1;
		pop();
		chk("rx idle tx", 16'h5a5a, g);
		ctl <= 32'h0000_0001;
		send(16'h1234);
		chk("mode", 16'h0, 16'(rv));
		ctl <= 32'h0000_0000;
		for (int i = 0; i < 33; i++) send(16'(i));
		chk("ovr", 16'h1, 16'(ovr));
		for (int i = 0; i < 32; i++) begin
			pop();
			chk("fifo", 16'(i), g);
		end
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("ovr after reset", 16'h0, {15'h0, ovr});
		chk("rx valid after reset", 16'h0, {15'h0, rv});
		stop_test();
	end
endmodule
bind spp_port spp_asserts u_chk (.CLK(CLK), .RST(RST), .ACTIVE(ACTIVE),
	.CHIP_SELECT_N(CHIP_SELECT_N), .PERIPH_TO_HOST_OE(PERIPH_TO_HOST_OE),
	.RX_VALID(RX_VALID), .RX_READY(RX_READY), .RX_OVERRUN(RX_OVERRUN),
	.GLOBAL_CONTROL_REG(GLOBAL_CONTROL_REG), .FORMAT_REG(FORMAT_REG),
	.RX_WORD(RX_WORD), .CLOCK_PRESCALE(CLOCK_PRESCALE));
